// >>> tclk_pkg.sv
`default_nettype none
package tclk_pkg;
    // word indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_ANALOG_CONTROL = 8'h07;
    localparam logic [7:0] IDX_ERROR_INJECTION = 8'h08;
    localparam logic [7:0] IDX_ANALOG_READBACK = 8'h09;
    localparam logic [7:0] IDX_IO_LOCK_STATUS = 8'h10;
    localparam logic [7:0] IDX_RX_LOCK_SUMMARY = 8'h14;
    // analog control field positions
    localparam int CTL_LOOPBACK_BIT = 31;
    localparam int CTL_READ_BIT = 30;
    localparam int CTL_WRITE_BIT = 29;
    localparam int CTL_SET_LSB = 4;
    localparam int CTL_SET_MSB = 28;
    localparam int CTL_CHAN_MSB = 3;
    localparam int RB_VALID_BIT = 25;
    // control field reset: eq 0011, gain 000, tap0 10000, tap1 00000, tap2 10000, vod 010
    localparam logic [24:0] CTL_SETTINGS_RESET = 25'h0620082;
    // readback and per-channel store reset; differs from the control field defaults
    localparam logic [24:0] SETTINGS_RESET = 25'h0020080;
    localparam logic [3:0] CHAN_LAST = 4'h9;
    localparam int NUM_CHAN = 10;
    // reserved lock status fills
    localparam logic [6:0] LOCK100_RSV_HI = 7'h7f;
    localparam logic [9:0] LOCK100_RSV_MID = 10'h3ff;
    localparam logic [24:0] LOCK40_RSV_HI = 25'h1ffffff;
    // serial clock is line rate over this divisor
    localparam int SERIAL_CLOCK_DIVISOR = 40;
    localparam int LINE_RATE_KBPS = 10312500;
    localparam int SERIAL_CLOCK_KHZ = LINE_RATE_KBPS / SERIAL_CLOCK_DIVISOR;
    // settings access latency in status clock cycles
    localparam logic [3:0] ACCESS_CYCLES = 4'h3;

    typedef struct packed {
        logic [3:0] eq;
        logic [2:0] dc_gain;
        logic [4:0] tap0;
        logic [4:0] tap1;
        logic [4:0] tap2;
        logic [2:0] vod;
    } tclk_settings_type;

    typedef struct packed {
        logic loopback;
        logic [1:0] err_inject;
        logic [3:0] channel;
    } tclk_ctrl_type;
endpackage : tclk_pkg
`default_nettype wire

// >>> tclk_settings_store.sv
`default_nettype none
// per-channel analog settings store with a fixed access latency
module tclk_settings_store #(
    parameter int NUM_CHAN = tclk_pkg::NUM_CHAN
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // request
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [3:0] i_channel,
    input wire tclk_pkg::tclk_settings_type i_wdata,
    // reply
    output logic o_busy,
    output logic o_done,
    output tclk_pkg::tclk_settings_type o_rdata
);
    tclk_pkg::tclk_settings_type mem [NUM_CHAN];
    logic [3:0] count;
    logic pending_read;
    logic [3:0] chan;

    // out-of-range channels are ignored so a bad select cannot alias a real lane
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                mem[i] <= tclk_pkg::SETTINGS_RESET;
            end
        end else if (i_write && !o_busy && i_channel <= tclk_pkg::CHAN_LAST) begin
            mem[i_channel] <= i_wdata;
        end
    end

    // access sequencer, mimics the slow analog reconfiguration path
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count <= 4'h0;
            pending_read <= 1'b0;
            chan <= 4'h0;
            o_done <= 1'b0;
            o_rdata <= tclk_pkg::SETTINGS_RESET;
        end else begin
            o_done <= 1'b0;
            if (count != 4'h0) begin
                count <= count - 4'h1;
                if (count == 4'h1) begin
                    o_done <= pending_read;
                    if (pending_read) begin
                        o_rdata <= (chan <= tclk_pkg::CHAN_LAST) ? mem[chan] : tclk_pkg::SETTINGS_RESET;
                    end
                end
            end else if (i_read || i_write) begin
                count <= tclk_pkg::ACCESS_CYCLES;
                pending_read <= i_read;
                chan <= i_channel;
            end
        end
    end

    assign o_busy = (count != 4'h0);
endmodule : tclk_settings_store
`default_nettype wire

// >>> tclk_regs.sv
// Decided for this implementation: the Wishbone interface to the registers.
`default_nettype none
// How it works
// - low four bits pick channel zero to nine
// - error inject pulses on rising control bits
// - readback bit 25 flags valid read data
// - readback low bits hold settings, bit 26 zero
// - readback bits 24:0 mirror control bits 28:4
// - bits 28:25 equalization, reset 0011
// - bits 24:22 dc gain, 3 dB steps
// - three pre-emphasis tap fields with resets
// - summary bit set when all pcs lanes normal
// - 100g: bits 24:22 tx pll locked
// - 100g: bits 11:2 per-lane cdr lock
// - 40g: bit 6 tx pll locked
// - 40g: bits 5:2 cdr lock lanes one-four
// - lock bit 1 shows tx interface ready
// - serial clocks are line rate over forty
// - control bit 30 triggers settings read
// - control bit 29 triggers settings write
// - control bit 31 enables serial loopback
module tclk_regs #(
    parameter bit IS_100G = 1'b1,
    parameter int NUM_LANES = 10
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // classic wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [9:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // status inputs from transceiver pins
    input wire logic [2:0] i_tx_pll_locked,
    input wire logic [NUM_LANES-1:0] i_rx_cdr_locked,
    input wire logic i_tx_ready,
    input wire logic i_rx_ready,
    input wire logic i_pcs_lanes_ok,
    // transceiver controls
    output logic o_loopback,
    output logic [1:0] o_err_inject,
    output logic [3:0] o_channel
);
    logic [31:0] analog_control;
    logic [1:0] error_injection_control;
    tclk_pkg::tclk_settings_type readback;
    logic readback_valid;
    logic [2:0] pll_s1, pll_s2;
    logic [NUM_LANES-1:0] cdr_s1, cdr_s2;
    logic [2:0] rdy_s1, rdy_s2;
    logic store_busy;
    logic store_done;
    tclk_pkg::tclk_settings_type store_rdata;
    logic wr_en;
    logic [7:0] word_idx;
    logic [31:0] io_lock_status;
    logic [31:0] read_word;

    // apply byte lanes to a stored word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] new_val,
                                                 input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    assign word_idx = i_wb_adr[9:2];
    assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;

    // two-flop synchronisers for asynchronous transceiver status
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pll_s1 <= 3'h0;
            pll_s2 <= 3'h0;
            cdr_s1 <= '0;
            cdr_s2 <= '0;
            rdy_s1 <= 3'h0;
            rdy_s2 <= 3'h0;
        end else begin
            pll_s1 <= i_tx_pll_locked;
            pll_s2 <= pll_s1;
            cdr_s1 <= i_rx_cdr_locked;
            cdr_s2 <= cdr_s1;
            rdy_s1 <= {i_pcs_lanes_ok, i_tx_ready, i_rx_ready};
            rdy_s2 <= rdy_s1;
        end
    end

    // single-cycle ack, one answer per request, registered one clock after the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
        end
    end

    // analog control word; read and write strobes self-clear after the access is launched
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            analog_control <= {3'b000, tclk_pkg::CTL_SETTINGS_RESET, 4'h0};
        end else if (wr_en && word_idx == tclk_pkg::IDX_ANALOG_CONTROL) begin
            analog_control <= merge_bytes(analog_control, i_wb_dat, i_wb_sel);
        end else if (!store_busy) begin
            analog_control[tclk_pkg::CTL_READ_BIT] <= 1'b0;
            analog_control[tclk_pkg::CTL_WRITE_BIT] <= 1'b0;
        end
    end

    // error inject: a one-cycle pulse per rising control bit, holding the bit does nothing more
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            error_injection_control <= 2'b00;
            o_err_inject <= 2'b00;
        end else begin
            o_err_inject <= 2'b00;
            if (wr_en && word_idx == tclk_pkg::IDX_ERROR_INJECTION && i_wb_sel[0]) begin
                error_injection_control <= i_wb_dat[1:0];
                o_err_inject <= i_wb_dat[1:0] & ~error_injection_control;
            end
        end
    end

    tclk_settings_store #(
        .NUM_CHAN(tclk_pkg::NUM_CHAN)
    ) u_store (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_read(analog_control[tclk_pkg::CTL_READ_BIT]),
        .i_write(analog_control[tclk_pkg::CTL_WRITE_BIT]),
        .i_channel(analog_control[tclk_pkg::CTL_CHAN_MSB:0]),
        .i_wdata(analog_control[tclk_pkg::CTL_SET_MSB:tclk_pkg::CTL_SET_LSB]),
        .o_busy(store_busy),
        .o_done(store_done),
        .o_rdata(store_rdata)
    );

    // readback capture; a new read request wins over an old completion
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            readback <= tclk_pkg::SETTINGS_RESET;
            readback_valid <= 1'b0;
        end else if (analog_control[tclk_pkg::CTL_READ_BIT] && !store_busy) begin
            readback_valid <= 1'b0;
        end else if (store_done) begin
            readback <= store_rdata;
            readback_valid <= 1'b1;
        end
    end

    // lock status word, layout depends on the rate option
    always_comb begin
        io_lock_status = 32'h0;
        if (IS_100G) begin
            io_lock_status[31:25] = tclk_pkg::LOCK100_RSV_HI;
            io_lock_status[24:22] = pll_s2;
            io_lock_status[21:12] = tclk_pkg::LOCK100_RSV_MID;
            io_lock_status[11:2] = cdr_s2[9:0];
        end else begin
            io_lock_status[31:7] = tclk_pkg::LOCK40_RSV_HI;
            io_lock_status[6] = pll_s2[0];
            io_lock_status[5:2] = cdr_s2[3:0];
        end
        io_lock_status[1] = rdy_s2[1];
        io_lock_status[0] = rdy_s2[0];
    end

    // read mux; unmapped words read zero and writes to status words are dropped
    always_comb begin
        case (word_idx)
            tclk_pkg::IDX_ANALOG_CONTROL: read_word = analog_control;
            tclk_pkg::IDX_ERROR_INJECTION: read_word = {30'h0, error_injection_control};
            tclk_pkg::IDX_ANALOG_READBACK: read_word = {6'h0, readback_valid, readback};
            tclk_pkg::IDX_IO_LOCK_STATUS: read_word = io_lock_status;
            tclk_pkg::IDX_RX_LOCK_SUMMARY: read_word = {31'h0, rdy_s2[2]};
            default: read_word = 32'h0;
        endcase
    end

    // registered read data
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wb_dat <= 32'h0;
        end else if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
            o_wb_dat <= read_word;
        end
    end

    // controls to the transceiver; serial clocks run at line rate / 40 outside this block
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_loopback <= 1'b0;
            o_channel <= 4'h0;
        end else begin
            o_loopback <= analog_control[tclk_pkg::CTL_LOOPBACK_BIT];
            o_channel <= analog_control[tclk_pkg::CTL_CHAN_MSB:0];
        end
    end
endmodule : tclk_regs
`default_nettype wire

// >>> tclk_regs_sva.sv
`default_nettype none
// pin-level checker for the status and control register block
module tclk_regs_sva #(
    parameter bit IS_100G = 1'b1,
    parameter int NUM_LANES = 10
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // wishbone
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [9:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // status and controls
    input wire logic [2:0] i_tx_pll_locked,
    input wire logic [NUM_LANES-1:0] i_rx_cdr_locked,
    input wire logic i_tx_ready,
    input wire logic i_rx_ready,
    input wire logic i_pcs_lanes_ok,
    input wire logic o_loopback,
    input wire logic [1:0] o_err_inject,
    input wire logic [3:0] o_channel
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // completed cycles, decoded by word index
    wire logic [7:0] idx = i_wb_adr[9:2];
    wire logic ack = o_wb_ack && i_wb_cyc && i_wb_stb;
    wire logic rd = ack && !i_wb_we;
    wire logic ctl_wr = ack && i_wb_we && idx == tclk_pkg::IDX_ANALOG_CONTROL && i_wb_sel == 4'hf;
    wire logic inj_wr = ack && i_wb_we && idx == tclk_pkg::IDX_ERROR_INJECTION && i_wb_sel[0];
    logic [31:0] ctl_q;
    logic [1:0] inj_q;
    // last control word; only read after a write, so no reset needed
    always_ff @(posedge i_clk) begin
        if (ctl_wr) begin
            ctl_q <= i_wb_dat;
        end
    end
    // old inject level, so a held bit is told apart from a rising one
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            inj_q <= 2'h0;
        end else if (inj_wr) begin
            inj_q <= i_wb_dat[1:0];
        end
    end
    chan_follow_a: assert property (ctl_wr |=> ##1 o_channel == ctl_q[3:0])
        else $error("channel output does not follow control word");
    loop_follow_a: assert property (ctl_wr |=> ##1 o_loopback == ctl_q[31])
        else $error("loopback output does not follow control word");
    inj_rise0_a: assert property (inj_wr && i_wb_dat[0] && !inj_q[0] |-> ##[0:2] o_err_inject[0])
        else $error("no inject pulse on rising bit 0");
    inj_rise1_a: assert property (inj_wr && i_wb_dat[1] && !inj_q[1] |-> ##[0:2] o_err_inject[1])
        else $error("no inject pulse on rising bit 1");
    inj_once_a: assert property (|o_err_inject |=> o_err_inject == 2'h0)
        else $error("inject pulse longer than one cycle");
    rb_rsv_a: assert property (rd && idx == tclk_pkg::IDX_ANALOG_READBACK |-> o_wb_dat[31:26] == 6'h0)
        else $error("readback upper bits not zero");
    lock_word_a: assert property (
        $stable({i_tx_pll_locked, i_rx_cdr_locked, i_tx_ready, i_rx_ready})[*5]
        ##0 (rd && idx == tclk_pkg::IDX_IO_LOCK_STATUS && IS_100G)
        |-> o_wb_dat == {tclk_pkg::LOCK100_RSV_HI, i_tx_pll_locked, tclk_pkg::LOCK100_RSV_MID,
            i_rx_cdr_locked, i_tx_ready, i_rx_ready})
        else $error("lock status word wrong");
    lock_summary_a: assert property (
        $stable(i_pcs_lanes_ok)[*5] ##0 (rd && idx == tclk_pkg::IDX_RX_LOCK_SUMMARY)
        |-> o_wb_dat[0] == i_pcs_lanes_ok)
        else $error("lock summary bit wrong");
endmodule : tclk_regs_sva
bind tclk_regs tclk_regs_sva #(.IS_100G(IS_100G), .NUM_LANES(NUM_LANES)) u_sva (.i_clk(i_clk), .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_tx_pll_locked(i_tx_pll_locked),
    .i_rx_cdr_locked(i_rx_cdr_locked), .i_tx_ready(i_tx_ready), .i_rx_ready(i_rx_ready),
    .i_pcs_lanes_ok(i_pcs_lanes_ok), .o_loopback(o_loopback), .o_err_inject(o_err_inject), .o_channel(o_channel));
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // design inputs, all valued at time zero
    logic i_clk = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, o_wb_ack, o_loopback;
    logic i_tx_ready = 1'b0, i_rx_ready = 1'b0, i_pcs_lanes_ok = 1'b0;
    logic [9:0] i_wb_adr = 10'h0, i_rx_cdr_locked = 10'h0;
    logic [3:0] i_wb_sel = 4'hf, o_channel;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, o_wb_dat40, rd;
    logic [2:0] i_tx_pll_locked = 3'h0;
    logic [1:0] o_err_inject;
    logic [24:0] sv = 25'h1a5b3c7;
    int failures = 0, comparisons = 0, pulses0 = 0, pulses1 = 0, p0, p1;
    typedef struct packed {logic we; logic [9:0] adr; logic [31:0] dat; logic [31:0] exp;} tclk_row_type;
    // plain accesses: reset values, ignored writes, unmapped word
    tclk_row_type rows [12] = '{
        '{1'b0, 10'h01c, 32'h0, 32'h06200820},
        '{1'b0, 10'h024, 32'h0, 32'h00020080},
        '{1'b0, 10'h040, 32'h0, 32'hfe3ff000},
        '{1'b1, 10'h040, 32'hffffffff, 32'h0},
        '{1'b0, 10'h040, 32'h0, 32'hfe3ff000},
        '{1'b0, 10'h03c, 32'h0, 32'h0},
        '{1'b1, 10'h01c, 32'h8fedcba5, 32'h0},
        '{1'b0, 10'h01c, 32'h0, 32'h8fedcba5},
        '{1'b1, 10'h024, 32'hffffffff, 32'h0},
        '{1'b0, 10'h024, 32'h0, 32'h00020080},
        '{1'b0, 10'h020, 32'h0, 32'h0},
        '{1'b0, 10'h050, 32'h0, 32'h0}};
    tclk_regs DUT (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_tx_pll_locked(i_tx_pll_locked), .i_rx_cdr_locked(i_rx_cdr_locked), .i_tx_ready(i_tx_ready),
        .i_rx_ready(i_rx_ready), .i_pcs_lanes_ok(i_pcs_lanes_ok), .o_loopback(o_loopback),
        .o_err_inject(o_err_inject), .o_channel(o_channel));
    // same bus and pins, 40g lock layout; only its read data is watched
    tclk_regs #(.IS_100G(1'b0), .NUM_LANES(10)) DUT40 (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
        .o_wb_dat(o_wb_dat40), .o_wb_ack(), .i_tx_pll_locked(i_tx_pll_locked),
        .i_rx_cdr_locked(i_rx_cdr_locked), .i_tx_ready(i_tx_ready), .i_rx_ready(i_rx_ready),
        .i_pcs_lanes_ok(i_pcs_lanes_ok), .o_loopback(), .o_err_inject(), .o_channel());
    // clock and inject pulse counters, sampled before the edge's updates land
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        pulses0 += int'(o_err_inject[0]);
        pulses1 += int'(o_err_inject[1]);
    end
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle; request held until ack is sampled, then a idle cycle
    task automatic wb(input logic we, input logic [9:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= adr;
        i_wb_dat <= dat;
        for (n = 0; n < 20 && (n == 0 || o_wb_ack !== 1'b1); n++) begin
            @(posedge i_clk);
        end
        if (o_wb_ack !== 1'b1) begin
            failures++;
            $display("ERROR %0t: no ack", $time);
            tally_and_finish();
        end
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_clk);
    endtask : wb
    // bounded poll of one bit; the register block has no completion pin
    task automatic poll(input logic [9:0] adr, input int b, input logic v, output logic [31:0] q);
        for (int n = 0; n < 30; n++) begin
            wb(1'b0, adr, 32'h0, q);
            if (q[b] === v) return;
        end
        failures++;
        $display("ERROR %0t: poll timed out", $time);
        tally_and_finish();
    endtask : poll
    task automatic do_reset();
        i_rst <= 1'b1;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
    endtask : do_reset
    initial begin
        do_reset();
        foreach (rows[k]) begin
            wb(rows[k].we, rows[k].adr, rows[k].dat, rd);
            if (!rows[k].we) chk(rd, rows[k].exp);
        end
        chk({27'h0, o_loopback, o_channel}, 32'h15);
        $display("test registers done");
        // write channel 7, read it back, then a fresh channel 2 read
        wb(1'b1, 10'h01c, {3'b001, sv, 4'h7}, rd);
        poll(10'h01c, 29, 1'b0, rd);
        wb(1'b1, 10'h01c, {3'b010, 25'h0, 4'h7}, rd);
        poll(10'h024, 25, 1'b1, rd);
        chk(rd, {7'h01, sv});
        poll(10'h01c, 30, 1'b0, rd);
        wb(1'b1, 10'h01c, {3'b010, 25'h0, 4'h2}, rd);
        wb(1'b0, 10'h024, 32'h0, rd);
        chk({31'h0, rd[25]}, 32'h0);
        poll(10'h024, 25, 1'b1, rd);
        chk(rd, {7'h01, tclk_pkg::SETTINGS_RESET});
        $display("test settings done");
        // byte lane 0 only: the upper data bytes must not land
        i_wb_sel <= 4'h1;
        wb(1'b1, 10'h01c, 32'hffffff39, rd);
        i_wb_sel <= 4'hf;
        wb(1'b0, 10'h01c, 32'h0, rd);
        chk(rd, 32'h00000039);
        chk({28'h0, o_channel}, 32'h9);
        $display("test byte lanes done");
        // held inject bits must not pulse again
        p0 = pulses0;
        p1 = pulses1;
        wb(1'b1, 10'h020, 32'h1, rd);
        wb(1'b1, 10'h020, 32'h1, rd);
        wb(1'b1, 10'h020, 32'h3, rd);
        repeat (3) @(posedge i_clk);
        chk(32'(pulses0 - p0), 32'h1);
        chk(32'(pulses1 - p1), 32'h1);
        $display("test inject done");
        // asymmetric patterns so a reversed or swapped field shows
        i_tx_pll_locked <= 3'h3;
        i_rx_cdr_locked <= 10'h2a5;
        i_tx_ready <= 1'b1;
        i_rx_ready <= 1'b0;
        i_pcs_lanes_ok <= 1'b1;
        repeat (5) @(posedge i_clk);
        wb(1'b0, 10'h040, 32'h0, rd);
        chk(rd, {7'h7f, 3'h3, 10'h3ff, 10'h2a5, 2'h2});
        chk(o_wb_dat40, {25'h1ffffff, 1'b1, 4'h5, 2'h2});
        wb(1'b0, 10'h050, 32'h0, rd);
        chk(rd, 32'h1);
        i_tx_ready <= 1'b0;
        i_rx_ready <= 1'b1;
        repeat (5) @(posedge i_clk);
        wb(1'b0, 10'h040, 32'h0, rd);
        chk({30'h0, rd[1:0]}, 32'h1);
        $display("test status done");
        do_reset();
        wb(1'b0, 10'h024, 32'h0, rd);
        chk(rd, 32'h00020080);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
